// file: common/standby_pkg.sv
// Purpose: Constants and types shared by the standby controller
// Assumes: 32-bit AHB-Lite register bus, 25 MHz system clock
// Notes:   Offsets are byte addresses
package standby_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] MODE_OFF = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h08;
    localparam logic [7:0] KEY_OFF  = 8'h0c;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int REQ_BIT      = 1;
    localparam int INT_MASK_BIT = 4;
    localparam int NMI_MASK_BIT = 5;
    localparam int WDT_MASK_BIT = 6;
    localparam int ARMED_BIT    = 2;

    // ----------------------------------------
    // Values
    // ----------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] UNLOCK_KEY = 8'ha5;
    localparam logic [1:0] SEL_LIGHT  = 2'h0;
    localparam int         NUM_EXT    = 15;
    localparam int         PRIO_W     = 3;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_HALT   = 2'b01,
        ST_LIGHT  = 2'b10
    } pm_state_t;

endpackage

// file: src/standby_ctrl.sv
// Purpose: Halt and light idle standby controller with AHB-Lite registers
// Assumes: CPU pulses halt_cmd when it executes the halt instruction
// Notes:   Deeper standby modes are not entered; their requests are dropped
//
// Behaviour
// R1: Software follows the halt instruction with five or more no-operations.
// R2: Halt with a pending unmasked request enters, then leaves at once.
// R3: Halt ends on nmi pin, watchdog irq, unmasked pins 0..14, internal irq.
// R4: Any reset source ends either standby state with a full reset.
// R5: Interrupt exit from halt restores normal mode with cpu clock on.
// R6: Any wake request ends halt regardless of priority.
// R7: In a service routine, lower priority wake stays pending, unacknowledged.
// R8: In a service routine, higher priority or nmi wake is acknowledged.
// R9: Non-maskable wake always branches to the handler.
// R10: Maskable wake branches only if enabled and acknowledged, else next instruction.
// R11: Port levels, registers and RAM stay frozen while halted.
// R12: Interval timer runs in halt unless counting subclock without subclock.
// R13: Selection 00 plus request bit set enters light idle.
// R14: Light idle keeps oscillator, PLL, flash; gates cpu and peripheral clocks.
// R15: Subclock and external-clock peripherals keep running in light idle.
// R16: RAM contents held unchanged throughout light idle.
// R17: Light idle exit needs no stabilisation wait.
// R18: Software follows the idle request store with five or more no-operations.
// R19: Pending unmasked request ends light idle immediately.
// R20: Light idle ends on nmi, watchdog, unmasked pins, running internal irq, reset.
// R21: Selection 00 light, 10 deep, 01/11 stop; valid only with request bit.
// R22: Three mask bits block nmi pin, watchdog and maskable idle release.
// R23: Mask bits are ignored for halt release.
// R24: Control register changes only through the unlock key sequence.
// R25: Separate clock enables per group, running after reset.
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module standby_ctrl
    import standby_pkg::*;
(
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rstn,
    // AHB-Lite slave
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    // Processor core and interrupt controller
    input  wire logic                          halt_cmd,
    input  wire logic                          global_irq_enabled,
    input  wire logic                          in_service,
    input  wire logic [standby_pkg::PRIO_W-1:0] service_prio,
    input  wire logic [standby_pkg::PRIO_W-1:0] req_prio,
    input  wire logic [standby_pkg::NUM_EXT-1:0] ext_irq_enable,
    input  wire logic                          int_irq_halt,
    input  wire logic                          int_irq_light,
    // Wake sources
    input  wire logic                          nmi_pin,
    input  wire logic [standby_pkg::NUM_EXT-1:0] ext_irq_pins,
    input  wire logic                          watchdog_irq,
    // Reset sources
    input  wire logic                          watchdog_reset,
    input  wire logic                          power_on_clear,
    input  wire logic                          low_voltage_detect,
    input  wire logic                          clock_monitor,
    // Timer configuration
    input  wire logic                          timer_on_subclock,
    input  wire logic                          subclock_used,
    // Clock enables and status
    output logic                               cpu_clk_en,
    output logic                               periph_clk_en,
    output logic                               ext_periph_clk_en,
    output logic                               interval_timer_en,
    output logic                               osc_pll_flash_en,
    output logic                               hold_state,
    output logic                               wake_branch,
    output logic                               wake_next,
    output logic                               sys_reset_req,
    output pm_state_t                          pm_state
);

    typedef struct packed {
        pm_state_t            st;
        logic [7:0]           ctrl;
        logic [1:0]           mode;
        logic                 armed;
        logic                 dp_wr;
        logic [7:0]           dp_addr;
        logic [31:0]          rdata;
        logic                 branch;
        logic                 next;
        logic                 rst_req;
        logic [2:0]           nmi_s;
        logic                 nmi_f;
        logic [NUM_EXT-1:0]   ext_s1;
        logic [NUM_EXT-1:0]   ext_s2;
        logic [NUM_EXT-1:0]   ext_s3;
        logic [NUM_EXT-1:0]   ext_f;
    } regs_t;

    regs_t r_q;
    regs_t r_d;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Filtered level moves only when the last two stages agree
    function automatic logic [NUM_EXT-1:0] agree(
        input logic [NUM_EXT-1:0] a,
        input logic [NUM_EXT-1:0] b,
        input logic [NUM_EXT-1:0] f
    );
        agree = (a & b) | (f & (a | b));
    endfunction

    // Exit kind as {branch, next}; exactly one of them is set
    // Shared by halt and light idle so both exits decide alike
    function automatic logic [1:0] exit_kind(
        input logic nmi,
        input logic msk,
        input logic ack
    );
        logic go_handler;
        go_handler = nmi | (msk & ack);
        exit_kind  = {go_handler, ~go_handler};
    endfunction

    logic               take;
    logic               nmi_any;
    logic               nmi_idle;
    logic               mask_halt;
    logic               mask_idle;
    logic               wake;
    logic               any_rst;
    logic               acked;
    logic [NUM_EXT-1:0] ext_hit;

    // ----------------------------------------
    // Wake decode
    // ----------------------------------------
    always_comb
    begin
        ext_hit   = r_q.ext_f & ext_irq_enable;
        nmi_any   = r_q.nmi_f | watchdog_irq;
        // Halt release ignores the mask bits
        mask_halt = (|ext_hit) | int_irq_halt; // R3 R23
        nmi_idle  = (r_q.nmi_f & ~r_q.ctrl[NMI_MASK_BIT])
                  | (watchdog_irq & ~r_q.ctrl[WDT_MASK_BIT]); // R22
        mask_idle = ((|ext_hit) | int_irq_light) & ~r_q.ctrl[INT_MASK_BIT]; // R20 R22
        case (r_q.st)
            ST_HALT:  wake = nmi_any | mask_halt; // R6
            ST_LIGHT: wake = nmi_idle | mask_idle; // R20
            default:  wake = 1'b0;
        endcase
        // Lower priority in a service routine wakes but is left pending
        acked = global_irq_enabled & (~in_service | (req_prio < service_prio)); // R7 R8 R10
        any_rst = watchdog_reset | power_on_clear | low_voltage_detect | clock_monitor;
        take = hsel & hready & htrans[1];
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        r_d         = r_q;
        r_d.branch  = 1'b0;
        r_d.next    = 1'b0;
        r_d.rst_req = any_rst; // R4
        r_d.nmi_s   = {r_q.nmi_s[1:0], nmi_pin};
        r_d.nmi_f   = (r_q.nmi_s[1] & r_q.nmi_s[2])
                    | (r_q.nmi_f & (r_q.nmi_s[1] | r_q.nmi_s[2]));
        r_d.ext_s1  = ext_irq_pins;
        r_d.ext_s2  = r_q.ext_s1;
        r_d.ext_s3  = r_q.ext_s2;
        r_d.ext_f   = agree(r_q.ext_s2, r_q.ext_s3, r_q.ext_f);

        // ----------------------------------------
        // Register bus
        // ----------------------------------------
        // Zero wait states: read data is registered in the address phase
        r_d.dp_wr = take & hwrite;
        if (take)
        begin
            r_d.dp_addr = haddr[7:0];
        end
        if (take & ~hwrite)
        begin
            case (haddr[7:0])
                CTRL_OFF: r_d.rdata = {24'h000000, r_q.ctrl};
                MODE_OFF: r_d.rdata = {30'h00000000, r_q.mode};
                STAT_OFF: r_d.rdata = {29'h00000000, r_q.armed, r_q.st};
                default:  r_d.rdata = 32'h00000000;
            endcase
        end
        if (r_q.dp_wr)
        begin
            r_d.armed = 1'b0;
            case (r_q.dp_addr)
                KEY_OFF: r_d.armed = (hwdata[7:0] == UNLOCK_KEY);
                MODE_OFF: r_d.mode = hwdata[1:0];
                CTRL_OFF:
                begin
                    if (r_q.armed) // R24
                    begin
                        r_d.ctrl[REQ_BIT] = hwdata[REQ_BIT];
                        // Masks written together with the request do not take
                        if (!hwdata[REQ_BIT])
                        begin
                            r_d.ctrl[WDT_MASK_BIT] = hwdata[WDT_MASK_BIT];
                            r_d.ctrl[NMI_MASK_BIT] = hwdata[NMI_MASK_BIT];
                            r_d.ctrl[INT_MASK_BIT] = hwdata[INT_MASK_BIT];
                        end
                    end
                end
                default: r_d.armed = 1'b0;
            endcase
        end

        // ----------------------------------------
        // Power state machine
        // ----------------------------------------
        case (r_q.st)
            ST_NORMAL:
            begin
                if (halt_cmd)
                begin
                    r_d.st = ST_HALT; // R2
                end
                else if (r_q.ctrl[REQ_BIT])
                begin
                    if (r_q.mode == SEL_LIGHT)
                    begin
                        r_d.st = ST_LIGHT; // R13 R21
                    end
                    else
                    begin
                        // Deep and stop modes are not built here
                        r_d.ctrl[REQ_BIT] = 1'b0; // R21
                    end
                end
            end
            ST_HALT, ST_LIGHT:
            begin
                // No stabilisation wait: back to normal on the next edge
                if (wake)
                begin
                    r_d.st            = ST_NORMAL; // R5 R17 R19
                    r_d.ctrl[REQ_BIT] = 1'b0;
                    if (r_q.st == ST_LIGHT)
                    begin
                        {r_d.branch, r_d.next} = exit_kind(nmi_idle, mask_idle, acked); // R9 R10
                    end
                    else
                    begin
                        {r_d.branch, r_d.next} = exit_kind(nmi_any, mask_halt, acked); // R9 R10
                    end
                end
            end
            default: r_d.st = ST_NORMAL;
        endcase

        // ----------------------------------------
        // Reset sources
        // ----------------------------------------
        // Override state, control, mode, key and wake pulses, so a wake in the same cycle gives no pulse
        if (any_rst)
        begin
            r_d.st     = ST_NORMAL; // R4
            r_d.ctrl   = CTRL_RESET;
            r_d.mode   = MODE_RESET;
            r_d.armed  = 1'b0;
            r_d.branch = 1'b0;
            r_d.next   = 1'b0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            r_q <= '0; // R25
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign hrdata            = r_q.rdata;
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign cpu_clk_en        = (r_q.st == ST_NORMAL); // R5 R25
    assign periph_clk_en     = (r_q.st != ST_LIGHT); // R14
    assign ext_periph_clk_en = 1'b1; // R15
    assign osc_pll_flash_en  = 1'b1; // R14
    // Light idle stops it unless a subclock count clock is present
    assign interval_timer_en = (r_q.st == ST_LIGHT)
                             ? (timer_on_subclock & subclock_used)
                             : ~(timer_on_subclock & ~subclock_used); // R12
    assign hold_state        = (r_q.st != ST_NORMAL); // R11 R16
    assign wake_branch       = r_q.branch;
    assign wake_next         = r_q.next;
    assign sys_reset_req     = r_q.rst_req;
    assign pm_state          = r_q.st;

endmodule

`default_nettype wire

// file: tb/core_model.sv
// Purpose: Processor core stand-in issuing the halt instruction
// Assumes: go is a one-cycle request from the bench
// Notes:   Refuses a new halt until five cycles after each wake
`timescale 1ns/10ps
`default_nettype none
module core_model
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // Bench request and wake pulses
    input  wire logic go,
    input  wire logic wake_branch,
    input  wire logic wake_next,
    // Halt instruction strobe
    output logic      halt_cmd
);
    logic [2:0] nop_q;
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            nop_q    <= 3'h0;
            halt_cmd <= 1'b0;
        end
        else
        begin
            // Five no-operations after a wake, so no halt meanwhile
            nop_q    <= (wake_branch || wake_next) ? 3'h5 :
                        ((nop_q != 3'h0) ? nop_q - 3'h1 : 3'h0);
            halt_cmd <= go && (nop_q == 3'h0) && !halt_cmd;
        end
    end
endmodule
`default_nettype wire

// file: tb/standby_ctrl_assertions.sv
// Purpose: Port checks for standby_ctrl
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached by bind from the bench top
`timescale 1ns/10ps
`default_nettype none
module standby_ctrl_assertions
    import standby_pkg::*;
(
    // Clock, reset and causes
    input wire logic      mclk, rstn, halt_cmd,
    input wire logic      watchdog_reset, power_on_clear, low_voltage_detect, clock_monitor,
    // Bus answer
    input wire logic      hreadyout, hresp,
    // Enables, pulses and state
    input wire logic      cpu_clk_en, periph_clk_en, ext_periph_clk_en, osc_pll_flash_en,
    input wire logic      hold_state, wake_branch, wake_next, sys_reset_req,
    input wire pm_state_t pm_state
);
    logic rs;
    assign rs = watchdog_reset | power_on_clear | low_voltage_detect | clock_monitor;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_halt_entry: assert property (pm_state == ST_NORMAL && halt_cmd && !rs |=>
        pm_state == ST_HALT) else $error("halt not entered");
    a_cpu_gate: assert property (cpu_clk_en == (pm_state == ST_NORMAL) &&
        hold_state == (pm_state != ST_NORMAL)) else $error("cpu enable wrong");
    a_light_gate: assert property (pm_state == ST_LIGHT |-> !periph_clk_en &&
        osc_pll_flash_en && ext_periph_clk_en) else $error("light gating wrong");
    a_halt_periph: assert property (pm_state == ST_HALT |-> periph_clk_en)
        else $error("peripherals stopped in halt");
    a_reset_exit: assert property (rs |=> pm_state == ST_NORMAL && !wake_branch
        && !wake_next) else $error("reset did not end standby");
    a_reset_req: assert property (rs [*2] |-> sys_reset_req)
        else $error("reset request missing");
    a_wake_exit: assert property (wake_branch || wake_next |->
        pm_state == ST_NORMAL && $past(hold_state)) else $error("stray wake pulse");
    a_wake_once: assert property (wake_branch || wake_next |-> !(wake_branch &&
        wake_next) ##1 !wake_branch && !wake_next) else $error("wake pulse shape");
    a_halt_release: assert property ((pm_state == ST_HALT && !rs) ##1
        pm_state == ST_NORMAL |-> wake_branch || wake_next) else $error("no wake pulse");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer wrong");
endmodule
`default_nettype wire

// file: tb/tb_standby_ctrl.sv
// Purpose: Self-checking bench for standby_ctrl
// Assumes: Inputs change just after rising edges
// Notes:   Pin wakes pass a filter, so waits are bounded loops
`timescale 1ns/10ps
`default_nettype none
module tb_standby_ctrl;
    import standby_pkg::*;
    logic        mclk = 1'b0, rstn = 1'b0, hsel = 1'b1, hwrite = 1'b0, go = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  service_prio = 3'h3, req_prio = 3'h3;
    logic [14:0] ext_irq_enable = 15'h4001;
    logic [5:0]  wk = 6'h0;
    logic [3:0]  rsrc = 4'h0;
    logic        global_irq_enabled = 1'b0, in_service = 1'b0, timer_on_subclock = 1'b1;
    logic        subclock_used = 1'b0, got_b = 1'b0, got_n = 1'b0;
    int          fails = 0, n_tests = 0, src[7] = '{0, 1, 2, 3, 4, 2, 4};
    logic [6:0]  gie = 7'b1111000, isv = 7'b0110000, br = 7'b1101011;
    logic [2:0]  rp[7] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h5, 3'h1, 3'h3};
    wire logic [31:0] hrdata;
    wire logic [14:0] ext_irq_pins;
    wire logic   hreadyout, hresp, halt_cmd, nmi_pin, watchdog_irq, int_irq_halt;
    wire logic   int_irq_light, watchdog_reset, power_on_clear, low_voltage_detect;
    wire logic   clock_monitor, cpu_clk_en, periph_clk_en, ext_periph_clk_en;
    wire logic   interval_timer_en, osc_pll_flash_en, hold_state, wake_branch, wake_next;
    wire logic   sys_reset_req;
    wire pm_state_t pm_state;
    assign {int_irq_light, int_irq_halt, watchdog_irq, nmi_pin} = {wk[5:4], wk[1:0]};
    assign ext_irq_pins = {wk[3], 13'h0, wk[2]};
    assign {clock_monitor, low_voltage_detect, power_on_clear, watchdog_reset} = rsrc;
    always #20 mclk = ~mclk;
    always @(posedge mclk)
    begin
        if (wake_branch === 1'b1) got_b <= 1'b1;
        if (wake_next === 1'b1) got_n <= 1'b1;
    end
    core_model cpu (.mclk, .rstn, .go, .wake_branch, .wake_next, .halt_cmd);
    standby_ctrl dut (.mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .halt_cmd, .global_irq_enabled,
        .in_service, .service_prio, .req_prio, .ext_irq_enable, .int_irq_halt,
        .int_irq_light, .nmi_pin, .ext_irq_pins, .watchdog_irq, .watchdog_reset,
        .power_on_clear, .low_voltage_detect, .clock_monitor, .timer_on_subclock,
        .subclock_used, .cpu_clk_en, .periph_clk_en, .ext_periph_clk_en,
        .interval_timer_en, .osc_pll_flash_en, .hold_state, .wake_branch, .wake_next,
        .sys_reset_req, .pm_state);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Single word transfer; data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hwrite <= w;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic ctl(input logic [31:0] d);
        bus(1'b1, KEY_OFF, {24'h0, UNLOCK_KEY});
        bus(1'b1, CTRL_OFF, d);
    endtask
    task automatic wait_st(input pm_state_t s);
        for (int i = 0; i < 20 && pm_state !== s; i++) @(posedge mclk);
        chk("state", s, pm_state);
    endtask
    task automatic halt_now;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        wait_st(ST_HALT);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        fails++;
        wrap_up();
    end
    initial
    begin
        tick(4);
        rstn <= 1'b1;
        tick(1);
        chk("cpu clk", 1, cpu_clk_en);
        chk("periph clk", 1, periph_clk_en);
        bus(1'b0, MODE_OFF, 0);
        chk("mode", 0, rd);
        bus(1'b1, 8'h10, 32'h5a);
        bus(1'b0, 8'h10, 0);
        chk("unmapped", 0, rd);
        ctl(32'h70);
        bus(1'b0, CTRL_OFF, 0);
        chk("masks", 32'h70, rd);
        for (int i = 0; i < 7; i++)
        begin
            global_irq_enabled <= gie[i];
            in_service <= isv[i];
            req_prio <= rp[i];
            got_b <= 1'b0;
            got_n <= 1'b0;
            if (i == 6) wk[4] <= 1'b1;
            halt_now();
            wk[src[i]] <= 1'b1;
            wait_st(ST_NORMAL);
            tick(1);
            chk("branch", br[i], got_b);
            chk("next", !br[i], got_n);
            wk <= 6'h0;
            tick(6);
        end
        $display("halt wake tests done");
        ext_irq_enable <= 15'h0001;
        for (int j = 0; j < 4; j++)
        begin
            got_b <= 1'b0;
            got_n <= 1'b0;
            halt_now();
            chk("halt timer", 0, interval_timer_en);
            chk("halt hold", 1, hold_state);
            wk[3] <= 1'b1;
            tick(8);
            chk("unenabled pin", ST_HALT, pm_state);
            rsrc[j] <= 1'b1;
            wait_st(ST_NORMAL);
            tick(1);
            chk("reset req", 1, sys_reset_req);
            chk("no pulse", 0, got_b | got_n);
            rsrc <= 4'h0;
            wk <= 6'h0;
            tick(6);
        end
        $display("reset tests done");
        subclock_used <= 1'b1;
        bus(1'b1, CTRL_OFF, 32'h2);
        tick(4);
        chk("unkeyed", ST_NORMAL, pm_state);
        ctl(32'h2);
        wait_st(ST_LIGHT);
        chk("periph clk", 0, periph_clk_en);
        chk("timer", 1, interval_timer_en);
        chk("ext periph", 1, ext_periph_clk_en);
        chk("osc pll", 1, osc_pll_flash_en);
        chk("light hold", 1, hold_state);
        chk("light cpu", 0, cpu_clk_en);
        bus(1'b0, STAT_OFF, 0);
        chk("stat", 2, rd);
        wk[5] <= 1'b1;
        wait_st(ST_NORMAL);
        bus(1'b0, CTRL_OFF, 0);
        chk("req clear", 0, rd);
        got_b <= 1'b0;
        got_n <= 1'b0;
        ctl(32'h2);
        tick(5);
        wait_st(ST_NORMAL);
        chk("pending exit", 1, got_b | got_n);
        wk <= 6'h0;
        ctl(32'h70);
        ctl(32'h72);
        wait_st(ST_LIGHT);
        wk <= 6'h23;
        tick(8);
        chk("masked wake", ST_LIGHT, pm_state);
        rsrc[2] <= 1'b1;
        wait_st(ST_NORMAL);
        rsrc <= 4'h0;
        wk <= 6'h0;
        tick(2);
        bus(1'b1, MODE_OFF, 32'h2);
        ctl(32'h2);
        tick(4);
        chk("deep dropped", ST_NORMAL, pm_state);
        $display("light idle tests done");
        wrap_up();
    end
endmodule
bind standby_ctrl standby_ctrl_assertions u_chk (.mclk, .rstn, .halt_cmd, .watchdog_reset,
    .power_on_clear, .low_voltage_detect, .clock_monitor, .hreadyout, .hresp, .cpu_clk_en,
    .periph_clk_en, .ext_periph_clk_en, .osc_pll_flash_en, .hold_state, .wake_branch,
    .wake_next, .sys_reset_req, .pm_state);
`default_nettype wire
